//--- shared/dsf_pkg.sv
// constants, register map and carrier types of the drive status flag block
package dsf_pkg;

   localparam int DATA_W = 32;
   localparam int WORD_W = 16;
   localparam int POS_W = 32;
   localparam int ADDR_W = 10;
   localparam int IDX_W = 8;
   localparam int SYNC_STAGES = 3;

   // register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS = 8'h00;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h01;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h02;

   // status word bit positions
   localparam int ST_REACHED = 0;
   localparam int ST_DRAG = 1;
   localparam int ST_KEY_REV = 2;
   localparam int ST_KEY_FWD = 3;
   localparam int ST_POWER = 4;
   localparam int ST_BITS = 5;
   localparam logic [ST_BITS-1:0] IRQ_MASK_RST = 5'h00;

   // motor supply window, threshold held in tenths of a volt
   localparam int VOLT_MAX_V = 30;
   localparam int VOLT_STEP_MV = 100;
   localparam logic [WORD_W-1:0] VOLT_MAX_CODE = WORD_W'(VOLT_MAX_V * 1000 / VOLT_STEP_MV);

   // parameter set: 0 position window, 1..11 motion set, 12 supply threshold
   localparam int NPARAM = 13;
   localparam int P_WINDOW = 0;
   localparam int P_MAX_CCW = 3;
   localparam int P_MAX_CW = 4;
   localparam int P_UMOT = 12;
   localparam logic [NPARAM-1:0][IDX_W-1:0] PARAM_IDX = {
      8'h68, 8'h4f, 8'h4e, 8'h4d, 8'h4c, 8'h48, 8'h47,
      8'h45, 8'h44, 8'h43, 8'h42, 8'h3e, 8'h38};
   localparam logic [NPARAM-1:0][WORD_W-1:0] PARAM_RST = {
      16'h00b9, 16'h001e, 16'h003c, 16'h0064, 16'h007d, 16'h0258, 16'h0258,
      16'h0050, 16'h00e6, 16'h00e6, 16'h00e6, 16'h0004, 16'h000a};

   typedef logic [NPARAM-1:0][WORD_W-1:0] dsf_param_t;

   // events and levels from the motion core, same clock
   typedef struct packed {
      logic target_load;
      logic target_ok;
      logic [POS_W-1:0] target_pos;
      logic [POS_W-1:0] actual_pos;
      logic arrived;
      logic ref_done;
      logic standstill;
      logic readjust_en;
      logic manual_start;
      logic run_cmd;
      logic accel_done;
      logic dir_cw;
      logic [WORD_W-1:0] speed_now;
      logic [WORD_W-1:0] motor_volt;
   } dsf_motion_s;

   function automatic logic [POS_W-1:0] dsf_absdiff(input logic [POS_W-1:0] a,
                                                    input logic [POS_W-1:0] b);
      logic signed [POS_W:0] d;
      d = $signed({a[POS_W-1], a}) - $signed({b[POS_W-1], b});
      if (d < 0) begin
         d = -d;
      end
      return d[POS_W-1:0];
   endfunction

endpackage

//--- hw/dsf_status_flags.sv
// status word flags, motion parameter set and apb register file of the drive
//
// How it works
// - set reached flag on successful arrival
// - after reference loop, set if actual equals target
// - displaced at standstill, readjusted within window: set
// - new target beyond window clears reached flag
// - manual run, invalid target, hand turning clear
// - below max speed after acceleration sets drag
// - a new run command clears drag error unless drag is detected in the same cycle
// - bit 2 follows reverse jog key input
// - bit 3 follows forward jog key input
// - bit 4 high only between threshold and 30 V
// - separate standstill and end-of-run holding torques, 30/60
// - supply threshold counted in tenths of a volt
`timescale 1ns/10ps

module dsf_status_flags (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dsf_pkg::ADDR_W-1:0] paddr,
   input wire logic [dsf_pkg::DATA_W-1:0] pwdata,
   output logic [dsf_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic key_rev_pin,
   input wire logic key_fwd_pin,
   input wire dsf_pkg::dsf_motion_s motion,
   output dsf_pkg::dsf_param_t param_out,
   output logic [dsf_pkg::ST_BITS-1:0] status_out,
   output logic irq
);
   import dsf_pkg::*;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic [IDX_W-1:0] idx;
   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic hit_status;
   logic hit_irq_stat;
   logic hit_irq_mask;
   logic [NPARAM-1:0] hit_param;
   logic hit_any;
   logic addr_aligned;

   assign idx = paddr[ADDR_W-1:2];
   assign addr_aligned = (paddr[1:0] == 2'b00);
   assign setup_phase = psel & ~penable;
   // pready comes from a flop, so completion is seen one cycle after setup
   assign access_done = psel & penable & pready;
   assign wr_done = access_done & pwrite;
   assign rd_done = access_done & ~pwrite;

   assign hit_status = addr_aligned & (idx == IDX_STATUS);
   assign hit_irq_stat = addr_aligned & (idx == IDX_IRQ_STAT);
   assign hit_irq_mask = addr_aligned & (idx == IDX_IRQ_MASK);

   genvar gi;
   generate
      for (gi = 0; gi < NPARAM; gi++) begin : g_hit
         assign hit_param[gi] = addr_aligned & (idx == PARAM_IDX[gi]);
      end
   endgenerate

   assign hit_any = hit_status | hit_irq_stat | hit_irq_mask | (|hit_param);

   // ---------------------------------------------------------------
   // parameter set
   // ---------------------------------------------------------------
   dsf_param_t param_reg;
   logic [NPARAM-1:0] param_we;

   // upper half of the bus word is dropped, parameters are 16-bit words
   assign param_we = hit_param & {NPARAM{wr_done}};

   // holding torques live in their own words, reset to the smallest model
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         param_reg <= PARAM_RST;
      end else begin
         for (int k = 0; k < NPARAM; k++) begin
            if (param_we[k]) begin
               param_reg[k] <= pwdata[WORD_W-1:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // jog key inputs: bit 0 reverse, bit 1 forward
   // ---------------------------------------------------------------
   logic [1:0] key_pins;
   logic [1:0] key_reg;
   logic [1:0] key_next;

   assign key_pins = {key_fwd_pin, key_rev_pin};

   // each key pin has its own three-flop filter
   generate
      for (gi = 0; gi < 2; gi++) begin : g_key
         dsf_pin_filter #(
            .STAGES(SYNC_STAGES)
         ) dsf_pin_filter_i (
            .pclk(pclk),
            .presetn(presetn),
            .pin(key_pins[gi]),
            .level_next(key_next[gi]),
            .level_reg(key_reg[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // target reached
   // ---------------------------------------------------------------
   logic [POS_W-1:0] target_reg;
   logic [POS_W-1:0] window;
   logic [POS_W-1:0] dist_now;
   logic [POS_W-1:0] dist_new;
   logic at_target;
   logic in_window;
   logic new_far;
   logic valid_load;
   logic invalid_load;
   logic hand_turn;
   logic displaced_reg;
   logic reached_reg;
   logic reached_set;
   logic reached_clr;
   logic reached_next;
   logic displaced_next;

   assign window = {{(POS_W-WORD_W){1'b0}}, param_reg[P_WINDOW]};
   assign dist_now = dsf_absdiff(motion.actual_pos, target_reg);
   assign dist_new = dsf_absdiff(motion.actual_pos, motion.target_pos);
   assign at_target = (motion.actual_pos == target_reg);
   assign in_window = (dist_now <= window);
   assign new_far = (dist_new > window);
   assign valid_load = motion.target_load & motion.target_ok;
   assign invalid_load = motion.target_load & ~motion.target_ok;
   // pushed off the target while stationary
   assign hand_turn = motion.standstill & ~in_window;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_reg <= '0;
      end else if (valid_load) begin
         target_reg <= motion.target_pos;
      end
   end

   // the arrival strobe is trusted as the success indication
   // a reference loop only counts when it ends on the stored target
   // readjusted back inside the window after a push
   assign reached_set = motion.arrived |
                        (motion.ref_done & at_target) |
                        (displaced_reg & motion.standstill & motion.readjust_en & in_window);

   // far new target manual run, bad target, turning by hand
   assign reached_clr = (valid_load & new_far) |
                        motion.manual_start |
                        invalid_load |
                        hand_turn;

   // a set in the same cycle as a clear wins, so arrival is never lost
   assign reached_next = reached_set | (reached_reg & ~reached_clr);

   // displaced state ends with any new motion request
   assign displaced_next = hand_turn |
                           (displaced_reg & ~(motion.target_load | motion.run_cmd |
                                              motion.manual_start | reached_set));

   // ---------------------------------------------------------------
   // drag error
   // ---------------------------------------------------------------
   logic drag_reg;
   logic drag_next;
   logic [WORD_W-1:0] speed_limit;
   logic drag_set;

   assign speed_limit = motion.dir_cw ? param_reg[P_MAX_CW] : param_reg[P_MAX_CCW];
   // checked once, when the acceleration phase ends
   assign drag_set = motion.accel_done & (motion.speed_now < speed_limit);
   // a run command clears, but a simultaneous detection still shows
   assign drag_next = drag_set | (drag_reg & ~motion.run_cmd);

   // ---------------------------------------------------------------
   // motor supply present
   // ---------------------------------------------------------------
   logic power_reg;
   logic power_next;

   // both sides in tenths of a volt, strict bounds on each
   assign power_next = (motion.motor_volt > param_reg[P_UMOT]) &
                       (motion.motor_volt < VOLT_MAX_CODE);

   // ---------------------------------------------------------------
   // flag registers, updated every cycle
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reached_reg <= 1'b0;
         displaced_reg <= 1'b0;
         drag_reg <= 1'b0;
         power_reg <= 1'b0;
      end else begin
         reached_reg <= reached_next;
         displaced_reg <= displaced_next;
         drag_reg <= drag_next;
         power_reg <= power_next;
      end
   end

   logic [ST_BITS-1:0] status_word;
   logic [ST_BITS-1:0] status_next;

   assign status_word[ST_REACHED] = reached_reg;
   assign status_word[ST_DRAG] = drag_reg;
   assign status_word[ST_KEY_REV] = key_reg[0];
   assign status_word[ST_KEY_FWD] = key_reg[1];
   assign status_word[ST_POWER] = power_reg;

   assign status_next[ST_REACHED] = reached_next;
   assign status_next[ST_DRAG] = drag_next;
   assign status_next[ST_KEY_REV] = key_next[0];
   assign status_next[ST_KEY_FWD] = key_next[1];
   assign status_next[ST_POWER] = power_next;

   // ---------------------------------------------------------------
   // interrupt: sticky on any flag change, cleared by reading it
   // ---------------------------------------------------------------
   logic [ST_BITS-1:0] irq_stat_reg;
   logic [ST_BITS-1:0] irq_mask_reg;
   logic [ST_BITS-1:0] irq_event;
   logic [ST_BITS-1:0] irq_stat_next;
   logic irq_clr;
   logic mask_we;

   assign irq_event = status_next ^ status_word;
   assign irq_clr = rd_done & hit_irq_stat;
   assign mask_we = wr_done & hit_irq_mask;
   // an edge landing on the clearing read stays set
   assign irq_stat_next = irq_event | (irq_stat_reg & {ST_BITS{~irq_clr}});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= IRQ_MASK_RST;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (mask_we) begin
            irq_mask_reg <= pwdata[ST_BITS-1:0];
         end
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // read mux and apb answer
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_param;
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      rd_param = '0;
      for (int k = 0; k < NPARAM; k++) begin
         if (hit_param[k]) begin
            rd_param = {{(DATA_W-WORD_W){1'b0}}, param_reg[k]};
         end
      end
   end

   // status is sampled at setup; reading it has no effect
   assign rd_mux = hit_status ? {{(DATA_W-ST_BITS){1'b0}}, status_word} :
                   hit_irq_stat ? {{(DATA_W-ST_BITS){1'b0}}, irq_stat_reg} :
                   hit_irq_mask ? {{(DATA_W-ST_BITS){1'b0}}, irq_mask_reg} :
                   rd_param;

   // one access cycle per transfer; all answers come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~hit_any;
         if (setup_phase) begin
            prdata <= (pwrite || !hit_any) ? '0 : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         param_out <= PARAM_RST;
         status_out <= '0;
      end else begin
         param_out <= param_reg;
         status_out <= status_word;
      end
   end

endmodule

// three-flop filter for one asynchronous pin
module dsf_pin_filter #(
   parameter int STAGES = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level_next,
   output logic level_reg
);
   logic [STAGES-1:0] sync_reg;

   // the first flop may be metastable, so only the next one reads it;
   // a change counts once the last two flops agree
   assign level_next = (sync_reg[STAGES-1] == sync_reg[STAGES-2]) ? sync_reg[STAGES-1] :
                       level_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_reg <= '0;
         level_reg <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[STAGES-2:0], pin};
         level_reg <= level_next;
      end
   end

endmodule

//--- testbench/dsf_status_flags_assertions.sv
// port-level assertions for the drive status flag block
`timescale 1ns/10ps
module dsf_status_flags_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dsf_pkg::ADDR_W-1:0] paddr,
   input wire logic [dsf_pkg::DATA_W-1:0] pwdata,
   input wire logic [dsf_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic key_rev_pin,
   input wire logic key_fwd_pin,
   input wire dsf_pkg::dsf_motion_s motion,
   input wire dsf_pkg::dsf_param_t param_out,
   input wire logic [dsf_pkg::ST_BITS-1:0] status_out,
   input wire logic irq
);
   import dsf_pkg::*;
   // param_out lags the register, so the band must hold a few cycles
   wire in_band = motion.motor_volt > param_out[P_UMOT] && motion.motor_volt < VOLT_MAX_CODE;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_one_ready;
      pready ##1 !pready;
   endsequence
   property p_reach_set;
      motion.arrived |-> ##2 status_out[ST_REACHED];
   endproperty
   a_reach_set: assert property (p_reach_set) else $error("reached not set");
   property p_reach_clr;
      (motion.manual_start || motion.target_load && !motion.target_ok) && !motion.arrived
         && !motion.ref_done && !motion.readjust_en |-> ##2 !status_out[ST_REACHED];
   endproperty
   a_reach_clr: assert property (p_reach_clr) else $error("reached not cleared");
   property p_drag_set;
      motion.accel_done && motion.speed_now < param_out[motion.dir_cw ? P_MAX_CW : P_MAX_CCW]
         |-> ##2 status_out[ST_DRAG];
   endproperty
   a_drag_set: assert property (p_drag_set) else $error("drag not set");
   property p_drag_clr;
      motion.run_cmd && !motion.accel_done |-> ##2 !status_out[ST_DRAG];
   endproperty
   a_drag_clr: assert property (p_drag_clr) else $error("drag not cleared");
   property p_key_rev;
      (key_rev_pin [*7] |-> status_out[ST_KEY_REV])
         and (!key_rev_pin [*7] |-> !status_out[ST_KEY_REV]);
   endproperty
   a_key_rev: assert property (p_key_rev) else $error("reverse key flag wrong");
   property p_key_fwd;
      (key_fwd_pin [*7] |-> status_out[ST_KEY_FWD])
         and (!key_fwd_pin [*7] |-> !status_out[ST_KEY_FWD]);
   endproperty
   a_key_fwd: assert property (p_key_fwd) else $error("forward key flag wrong");
   property p_power;
      (in_band [*4] |-> status_out[ST_POWER]) and (!in_band [*4] |-> !status_out[ST_POWER]);
   endproperty
   a_power: assert property (p_power) else $error("supply flag wrong");
   property p_ready;
      s_setup |=> s_one_ready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle");
   for (genvar k = 0; k < NPARAM; k++) begin : g_prm
      property p_param_rd;
         psel && penable && pready && !pwrite && paddr == {PARAM_IDX[k], 2'b00}
            |-> !pslverr && prdata == {16'h0000, param_out[k]};
      endproperty
      a_param_rd: assert property (p_param_rd) else $error("parameter read wrong");
   end
endmodule

//--- testbench/test_drive_status_flag_logic.sv
// self-checking bench for the drive status flag block
`timescale 1ns/10ps
module test_drive_status_flag_logic;
   import dsf_pkg::*;
   localparam logic [9:0] A_ST = {IDX_STATUS, 2'b00};
   localparam logic [9:0] A_IS = {IDX_IRQ_STAT, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic key_rev_pin = 1'b0;
   logic key_fwd_pin = 1'b0;
   dsf_motion_s motion = '0;
   dsf_param_t param_out;
   logic [ST_BITS-1:0] status_out;
   logic irq;
   logic [64:0] expq[$];
   logic [64:0] e;
   logic [31:0] rng = 32'h0001_5def;
   int fails = 0;
   int comparisons = 0;
   always #2 pclk = ~pclk;
   dsf_status_flags dsf_status_flags_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .key_rev_pin, .key_fwd_pin, .motion, .param_out,
      .status_out, .irq);
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic check(string nm, logic [32:0] x, logic [32:0] g);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, x, g);
      end
   endtask
   task automatic check_irq(logic x);
      comparisons++;
      if (irq !== x) begin
         fails++;
         $display("unexpected irq: expected %b, seen %b", x, irq);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic apb(logic w, logic [9:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         check("pready", 33'(1'b1), 33'(pready));
         summarize();
      end
   endtask
   task automatic rd(logic [9:0] a, logic [31:0] d, logic r = 1'b0, logic [31:0] c = '1);
      expq.push_back({c, r, d});
      apb(1'b0, a, '0);
   endtask
   task automatic wr(logic [7:0] i, logic [31:0] d);
      apb(1'b1, {i, 2'b00}, d);
   endtask
   // pulses last exactly one cycle; two more edges let status settle
   task automatic step(logic [4:0] s);
      @(posedge pclk);
      motion.target_load <= 1'b0;
      motion.arrived <= 1'b0;
      motion.ref_done <= 1'b0;
      motion.manual_start <= 1'b0;
      motion.run_cmd <= 1'b0;
      motion.accel_done <= 1'b0;
      repeat (2) @(posedge pclk);
      rd(A_ST, 32'(s));
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (expq.size() == 0) begin
            check("read count", '0, '1);
         end else begin
            e = expq.pop_front();
            check("read", {e[32], e[31:0] & e[64:33]}, {pslverr, prdata & e[64:33]});
         end
      end
   end
   initial begin
      logic [31:0] d;
      logic [15:0] v;
      logic [15:0] thr;
      logic [15:0] vt[8];
      vt = '{16'h00b9, 16'h00ba, 16'h012b, 16'h012c, 16'h00f0, 16'h00f1, 16'h0000, 16'hffff};
      thr = 16'h00b9;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < NPARAM; k++) begin
         rd({PARAM_IDX[k], 2'b00}, 32'(PARAM_RST[k]));
      end
      rd({8'h4f, 2'b00}, 32'h0000_001e);
      rd({8'h4e, 2'b00}, 32'h0000_003c);
      rd(A_ST, '0);
      rd({IDX_IRQ_MASK, 2'b00}, '0);
      for (int k = 1; k < NPARAM - 1; k++) begin
         d = xs();
         wr(PARAM_IDX[k], d);
         rd({PARAM_IDX[k], 2'b00}, {16'h0000, d[15:0]});
      end
      rd(10'h014, '0, 1'b1);
      rd(10'h0f9, '0, 1'b1);
      wr(IDX_STATUS, '1);
      wr(8'h43, 32'h0000_0096);
      wr(8'h44, 32'h0000_00c8);
      motion.arrived <= 1'b1;
      step(5'h01);
      motion.target_load <= 1'b1;
      motion.target_ok <= 1'b1;
      motion.target_pos <= 32'h0000_0064;
      step(5'h00);
      motion.arrived <= 1'b1;
      step(5'h01);
      motion.target_load <= 1'b1;
      motion.target_pos <= 32'h0000_000a;
      step(5'h01);
      motion.target_load <= 1'b1;
      motion.target_pos <= 32'hffff_fff5;
      step(5'h00);
      motion.actual_pos <= 32'hffff_fff5;
      motion.ref_done <= 1'b1;
      step(5'h01);
      motion.manual_start <= 1'b1;
      step(5'h00);
      motion.actual_pos <= 32'hffff_fff6;
      motion.ref_done <= 1'b1;
      step(5'h00);
      motion.arrived <= 1'b1;
      step(5'h01);
      motion.standstill <= 1'b1;
      motion.actual_pos <= '0;
      step(5'h00);
      motion.readjust_en <= 1'b1;
      motion.actual_pos <= 32'hffff_ffff;
      step(5'h01);
      motion.standstill <= 1'b0;
      motion.readjust_en <= 1'b0;
      motion.target_load <= 1'b1;
      motion.target_ok <= 1'b0;
      step(5'h00);
      rd(A_IS, '0, 1'b0, '0);
      wr(IDX_IRQ_MASK, 32'h0000_0002);
      motion.dir_cw <= 1'b1;
      motion.speed_now <= 16'h00c7;
      motion.accel_done <= 1'b1;
      step(5'h02);
      check_irq(1'b1);
      rd(A_IS, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      check_irq(1'b0);
      wr(IDX_IRQ_MASK, '0);
      motion.run_cmd <= 1'b1;
      step(5'h00);
      check_irq(1'b0);
      rd(A_IS, 32'h0000_0002);
      motion.speed_now <= 16'h00c8;
      motion.accel_done <= 1'b1;
      step(5'h00);
      motion.dir_cw <= 1'b0;
      motion.speed_now <= 16'h0095;
      motion.accel_done <= 1'b1;
      step(5'h02);
      for (int i = 0; i < 12; i++) begin
         d = xs();
         v = vt[i % 8];
         if (i == 4) begin
            thr = 16'h00f0;
            wr(8'h68, 32'(thr));
         end
         key_rev_pin <= d[0];
         key_fwd_pin <= d[1];
         motion.motor_volt <= v;
         repeat (8) @(posedge pclk);
         d = 32'({v > thr && v < 16'h012c, d[1:0], 2'b00});
         rd(A_ST, d, 1'b0, 32'h0000_001c);
      end
      repeat (5) @(posedge pclk);
      check("read queue", '0, 33'(expq.size()));
      summarize();
   end
endmodule
bind dsf_status_flags dsf_status_flags_checker dsf_status_flags_checker_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_rev_pin,
   .key_fwd_pin, .motion, .param_out, .status_out, .irq);
